// ### hdl/asc_pkg.sv
// asc_pkg: addresses, fields, reset values and encodings of the converter control block
package asc_pkg;
    // ----------------------------------------
    // special function register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL1 = 8'hDD;
    localparam logic [7:0] ADDR_DECIM_LO = 8'hDE;
    localparam logic [7:0] ADDR_DECIM_HI = 8'hDF;
    localparam logic [7:0] ADDR_SSCTRL = 8'hE1;
    localparam logic [7:0] ADDR_SUM0 = 8'hE2;
    localparam logic [7:0] ADDR_SUM1 = 8'hE3;
    localparam logic [7:0] ADDR_SUM2 = 8'hE4;
    localparam logic [7:0] ADDR_SUM3 = 8'hE5;
    localparam logic [7:0] ADDR_OFFSET_DAC_CODE = 8'hE6;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_DECIM_LO = 8'h1B;
    localparam logic [2:0] RST_DECIM_HI = 3'h6;
    localparam logic [7:0] RST_SSCTRL = 8'h00;
    localparam logic [7:0] RST_OFFSET_DAC_CODE = 8'h00;
    localparam logic [31:0] RST_SUM = 32'h0000_0000;
    // ----------------------------------------
    // field positions and codes
    // ----------------------------------------
    localparam int POL_BIT = 6;
    localparam int SM_HI = 5;
    localparam int SM_LO = 4;
    localparam int CAL_HI = 2;
    localparam int SS_MODE_HI = 7;
    localparam int SS_MODE_LO = 6;
    localparam int SS_CNT_HI = 5;
    localparam int SS_CNT_LO = 3;
    localparam int SS_SHF_HI = 2;
    localparam int OFFSET_DAC_CODE_SIGN_BIT = 7;
    localparam logic [2:0] CAL_NONE = 3'h0;
    localparam logic [2:0] CAL_RSVD_A = 3'h6;
    localparam logic [2:0] CAL_RSVD_B = 3'h7;
    localparam logic [1:0] SUM_CPU_ADD = 2'h0;
    localparam logic [1:0] SUM_ADC_ACC = 2'h1;
    localparam logic [1:0] SUM_SHIFT = 2'h2;
    localparam logic [1:0] SUM_ACC_SHIFT = 2'h3;
    localparam logic [6:0] OFFSET_DAC_CODE_MAG_ZERO = 7'h00;
    localparam logic [8:0] COUNT_BASE = 9'h002;
    localparam logic [3:0] SHIFT_BASE = 4'h1;
    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int RESULT_W = 24;
    localparam int SUM_W = 32;
    localparam int DECIM_W = 11;
    localparam int DECIM_SHIFT = 6;
    localparam int DECIM_CNT_W = DECIM_W + DECIM_SHIFT;
    localparam logic [1:0] SHIFT_LAST = 2'h3;
    typedef enum logic [1:0] {ASC_IDLE, ASC_ACCUM, ASC_SHIFTING} asc_state_t;
endpackage

// ### hdl/asc_rate_if.sv
// asc_rate_if: decimation settings to the data rate generator and its tick back
`timescale 1ns/10ps
`default_nettype none
interface asc_rate_if;
    logic [10:0] decimRatio;
    logic [7:0] clkDivider;
    logic tick;
    modport ctrl (output decimRatio, output clkDivider, input tick);
    modport gen (input decimRatio, input clkDivider, output tick);
endinterface
`default_nettype wire

// ### hdl/asc_rate_gen.sv
// asc_rate_gen: one-cycle tick at the converter output data rate
`timescale 1ns/10ps
`default_nettype none
module asc_rate_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic run,
    asc_rate_if.gen rate
);
    import asc_pkg::*;

    logic [7:0] pre;
    logic [7:0] next_pre;
    logic [DECIM_CNT_W-1:0] cnt;
    logic [DECIM_CNT_W-1:0] next_cnt;
    logic [DECIM_CNT_W-1:0] limit;
    logic tick;
    logic next_tick;

    // --------------------------------------------
    // divide by (divider+1), then by 64 * ratio
    // --------------------------------------------
    always_comb begin
        limit = DECIM_CNT_W'(rate.decimRatio) << DECIM_SHIFT;
        if (rate.decimRatio == '0) begin
            limit = DECIM_CNT_W'(1) << DECIM_SHIFT;
        end
        next_pre = pre;
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run) begin
            next_pre = '0;
            next_cnt = '0;
        end else if (pre >= rate.clkDivider) begin
            next_pre = '0;
            if (cnt >= limit - DECIM_CNT_W'(1)) begin
                next_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + DECIM_CNT_W'(1);
            end
        end else begin
            next_pre = pre + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre <= '0;
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            pre <= next_pre;
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

    assign rate.tick = tick;
endmodule // asc_rate_gen
`default_nettype wire

// ### hdl/asc_adc_sum_cal.sv
// asc_adc_sum_cal: calibration, decimation, offset code and 32-bit summation unit
// Summary of operation
// - A calibration field write of code 1 to 5 starts that calibration kind; field always reads back zero.
// - Eleven-bit decimation ratio: low byte resets 1Bh, top three bits reset 06h.
// - Data rate is clock over (divider plus one) times 64 times decimation ratio.
// - Summation unit is idle and frozen while the converter is powered down.
// - Writing zero to summation control clears the whole 32-bit sum.
// - Bipolar polarity sign-extends converter values into the sum.
// - Mode 00: writing sum byte 0 adds the four written bytes.
// - Mode 01: each converter result is added and counted toward the count.
// - Mode 10: sum shifts right by code plus one within four clocks.
// - Mode 11: accumulate for the count, then shift the total.
// - Completion raises the summation interrupt; count codes select 2 through 256.
// - Reading sum byte 0 clears the summation interrupt; software clears aux flag.
// - Sum is visible as four bytes E2h to E5h, low byte first.
// - Offset code: bit 7 sign, bits 6..0 magnitude, added before conversion.
// - Offset codes 00h and 80h switch the offset converter off.
// - Polarity bit 0 selects bipolar, 1 unipolar, for result and sum.
// - Device raises the auxiliary source; software clears the flag in its handler.
`timescale 1ns/10ps
`default_nettype none
module asc_adc_sum_cal (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWe,
    input wire logic sfrRe,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    // converter side
    input wire logic adcPowerDown,
    input wire logic adcResultValid,
    input wire logic [asc_pkg::RESULT_W-1:0] adcResult,
    input wire logic [7:0] converterClockDivider,
    output logic calStart,
    output logic [2:0] calMode,
    output logic resultPolarity,
    output logic [1:0] settlingMode,
    output logic [asc_pkg::DECIM_W-1:0] decimRatio,
    output logic dataRateTick,
    output logic odacEnable,
    output logic odacNegative,
    output logic [6:0] odacMagnitude,
    // interrupt source
    output logic sumIrq
);
    import asc_pkg::*;

    // --------------------------------------------
    // helpers
    // --------------------------------------------
    function automatic logic [8:0] sumCountOf(input logic [2:0] code);
        return COUNT_BASE << code;
    endfunction

    function automatic logic [3:0] shiftOf(input logic [2:0] code);
        return {1'b0, code} + SHIFT_BASE;
    endfunction

    function automatic logic [SUM_W-1:0] extendResult(input logic [RESULT_W-1:0] res, input logic unipolar);
        if (unipolar) begin
            return {{(SUM_W-RESULT_W){1'b0}}, res};
        end
        return {{(SUM_W-RESULT_W){res[RESULT_W-1]}}, res};
    endfunction

    // --------------------------------------------
    // state
    // --------------------------------------------
    logic [7:0] ctrl1;
    logic [7:0] next_ctrl1;
    logic [7:0] decimLo;
    logic [7:0] next_decimLo;
    logic [2:0] decimHi;
    logic [2:0] next_decimHi;
    logic [7:0] ssctrl;
    logic [7:0] next_ssctrl;
    logic [23:0] sumHold;
    logic [23:0] next_sumHold;
    logic [SUM_W-1:0] sumAcc;
    logic [SUM_W-1:0] next_sumAcc;
    logic [7:0] offset_dac_code;
    logic [7:0] next_offset_dac_code;
    asc_state_t state;
    asc_state_t next_state;
    logic [8:0] sumCnt;
    logic [8:0] next_sumCnt;
    logic [1:0] shiftCnt;
    logic [1:0] next_shiftCnt;
    logic next_sumIrq;
    logic next_calStart;
    logic [2:0] next_calMode;
    logic [7:0] next_sfrRdata;
    logic next_odacEnable;
    logic [1:0] sumMode;
    logic sumDone;
    logic wrCtrl1;
    logic wrSsctrl;
    logic wrSum0;
    logic rdSum0;

    asc_rate_if rateBus ();

    assign sumMode = ssctrl[SS_MODE_HI:SS_MODE_LO];
    assign wrCtrl1 = sfrWe && (sfrAddr == ADDR_CTRL1);
    assign wrSsctrl = sfrWe && (sfrAddr == ADDR_SSCTRL);
    assign wrSum0 = sfrWe && (sfrAddr == ADDR_SUM0);
    assign rdSum0 = sfrRe && (sfrAddr == ADDR_SUM0);

    // --------------------------------------------
    // data rate generator
    // --------------------------------------------
    assign rateBus.decimRatio = {decimHi, decimLo};
    assign rateBus.clkDivider = converterClockDivider;

    asc_rate_gen rateGen (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(!adcPowerDown),
        .rate(rateBus)
    );

    // --------------------------------------------
    // register writes and calibration trigger
    // --------------------------------------------
    always_comb begin
        next_ctrl1 = ctrl1;
        next_decimLo = decimLo;
        next_decimHi = decimHi;
        next_ssctrl = ssctrl;
        next_sumHold = sumHold;
        next_offset_dac_code = offset_dac_code;
        next_odacEnable = odacEnable;
        next_calStart = 1'b0;
        next_calMode = calMode;
        if (sfrWe) begin
            unique case (sfrAddr)
                ADDR_CTRL1: begin
                    next_ctrl1 = {1'b0, sfrWdata[POL_BIT:SM_LO], 4'h0};
                    if (sfrWdata[CAL_HI:0] != CAL_RSVD_A && sfrWdata[CAL_HI:0] != CAL_RSVD_B) begin
                        next_calStart = (sfrWdata[CAL_HI:0] != CAL_NONE);
                        next_calMode = sfrWdata[CAL_HI:0];
                    end
                end
                ADDR_DECIM_LO: next_decimLo = sfrWdata;
                ADDR_DECIM_HI: next_decimHi = sfrWdata[2:0];
                ADDR_SSCTRL: next_ssctrl = sfrWdata;
                ADDR_SUM1: next_sumHold[7:0] = sfrWdata;
                ADDR_SUM2: next_sumHold[15:8] = sfrWdata;
                ADDR_SUM3: next_sumHold[23:16] = sfrWdata;
                ADDR_OFFSET_DAC_CODE: begin
                    next_offset_dac_code = sfrWdata;
                    next_odacEnable = (sfrWdata[6:0] != OFFSET_DAC_CODE_MAG_ZERO);
                end
                default: ;
            endcase
        end
    end

    // --------------------------------------------
    // summation and shift sequencer
    // --------------------------------------------
    always_comb begin
        next_state = state;
        next_sumAcc = sumAcc;
        next_sumCnt = sumCnt;
        next_shiftCnt = shiftCnt;
        sumDone = 1'b0;
        if (adcPowerDown) begin
            next_state = ASC_IDLE;
            next_sumCnt = '0;
            next_shiftCnt = '0;
        end else if (wrSsctrl) begin
            next_sumCnt = '0;
            next_shiftCnt = '0;
            if (sfrWdata == RST_SSCTRL) begin
                next_sumAcc = RST_SUM;
                next_state = ASC_IDLE;
            end else begin
                unique case (sfrWdata[SS_MODE_HI:SS_MODE_LO])
                    SUM_CPU_ADD: next_state = ASC_IDLE;
                    SUM_SHIFT: next_state = ASC_SHIFTING;
                    default: next_state = ASC_ACCUM;
                endcase
            end
        end else if (wrSum0 && state == ASC_IDLE && sumMode == SUM_CPU_ADD) begin
            next_sumAcc = sumAcc + {sumHold, sfrWdata};
        end else begin
            unique case (state)
                ASC_IDLE: ;
                ASC_ACCUM: begin
                    if (adcResultValid) begin
                        next_sumAcc = sumAcc + extendResult(adcResult, resultPolarity);
                        if (sumCnt + 9'h001 >= sumCountOf(ssctrl[SS_CNT_HI:SS_CNT_LO])) begin
                            next_sumCnt = '0;
                            if (sumMode == SUM_ACC_SHIFT) begin
                                next_state = ASC_SHIFTING;
                            end else begin
                                sumDone = 1'b1;
                            end
                        end else begin
                            next_sumCnt = sumCnt + 9'h001;
                        end
                    end
                end
                ASC_SHIFTING: begin
                    if (shiftCnt == SHIFT_LAST) begin
                        if (resultPolarity) begin
                            next_sumAcc = sumAcc >> shiftOf(ssctrl[SS_SHF_HI:0]);
                        end else begin
                            next_sumAcc = SUM_W'($signed(sumAcc) >>> shiftOf(ssctrl[SS_SHF_HI:0]));
                        end
                        next_shiftCnt = '0;
                        next_state = ASC_IDLE;
                        sumDone = 1'b1;
                    end else begin
                        next_shiftCnt = shiftCnt + 2'h1;
                    end
                end
            endcase
        end
        // set wins over the read clear
        next_sumIrq = sumIrq;
        if (rdSum0) begin
            next_sumIrq = 1'b0;
        end
        if (sumDone) begin
            next_sumIrq = 1'b1;
        end
    end

    // --------------------------------------------
    // read mux
    // --------------------------------------------
    always_comb begin
        next_sfrRdata = sfrRdata;
        if (sfrRe) begin
            unique case (sfrAddr)
                ADDR_CTRL1: next_sfrRdata = ctrl1;
                ADDR_DECIM_LO: next_sfrRdata = decimLo;
                ADDR_DECIM_HI: next_sfrRdata = {5'h00, decimHi};
                ADDR_SSCTRL: next_sfrRdata = ssctrl;
                ADDR_SUM0: next_sfrRdata = sumAcc[7:0];
                ADDR_SUM1: next_sfrRdata = sumAcc[15:8];
                ADDR_SUM2: next_sfrRdata = sumAcc[23:16];
                ADDR_SUM3: next_sfrRdata = sumAcc[31:24];
                ADDR_OFFSET_DAC_CODE: next_sfrRdata = offset_dac_code;
                default: next_sfrRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl1 <= RST_CTRL1;
            decimLo <= RST_DECIM_LO;
            decimHi <= RST_DECIM_HI;
            ssctrl <= RST_SSCTRL;
            sumHold <= '0;
            sumAcc <= RST_SUM;
            offset_dac_code <= RST_OFFSET_DAC_CODE;
            odacEnable <= 1'b0;
            state <= ASC_IDLE;
            sumCnt <= '0;
            shiftCnt <= '0;
            sumIrq <= 1'b0;
            calStart <= 1'b0;
            calMode <= CAL_NONE;
            sfrRdata <= 8'h00;
            dataRateTick <= 1'b0;
        end else begin
            ctrl1 <= next_ctrl1;
            decimLo <= next_decimLo;
            decimHi <= next_decimHi;
            ssctrl <= next_ssctrl;
            sumHold <= next_sumHold;
            sumAcc <= next_sumAcc;
            offset_dac_code <= next_offset_dac_code;
            odacEnable <= next_odacEnable;
            state <= next_state;
            sumCnt <= next_sumCnt;
            shiftCnt <= next_shiftCnt;
            sumIrq <= next_sumIrq;
            calStart <= next_calStart;
            calMode <= next_calMode;
            sfrRdata <= next_sfrRdata;
            dataRateTick <= rateBus.tick;
        end
    end

    assign resultPolarity = ctrl1[POL_BIT];
    assign settlingMode = ctrl1[SM_HI:SM_LO];
    assign decimRatio = {decimHi, decimLo};
    assign odacNegative = offset_dac_code[OFFSET_DAC_CODE_SIGN_BIT];
    assign odacMagnitude = offset_dac_code[6:0];

    // --------------------------------------------
    // assertions
    // --------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_cal_read_zero;
        sfrRe && sfrAddr == ADDR_CTRL1 |=> sfrRdata[CAL_HI:0] == CAL_NONE;
    endproperty
    a_cal_read_zero: assert property (p_cal_read_zero) else $error("calibration field read not zero");

    property p_cal_start;
        wrCtrl1 && sfrWdata[CAL_HI:0] != CAL_NONE && sfrWdata[CAL_HI:0] < CAL_RSVD_A
            |=> calStart && calMode == $past(sfrWdata[CAL_HI:0]) ##1 (!calStart || $past(wrCtrl1));
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration not started for written code");

    property p_cal_reserved;
        wrCtrl1 && sfrWdata[CAL_HI:0] >= CAL_RSVD_A |=> !calStart && $stable(calMode);
    endproperty
    a_cal_reserved: assert property (p_cal_reserved) else $error("reserved calibration code started one");

    property p_powered_down;
        adcPowerDown ##1 adcPowerDown |-> $stable(sumAcc) && state == ASC_IDLE;
    endproperty
    a_powered_down: assert property (p_powered_down) else $error("summation active while powered down");

    property p_clear_sum;
        wrSsctrl && sfrWdata == RST_SSCTRL && !adcPowerDown |=> sumAcc == RST_SUM;
    endproperty
    a_clear_sum: assert property (p_clear_sum) else $error("zero control write did not clear sum");

    property p_cpu_add;
        wrSum0 && state == ASC_IDLE && sumMode == SUM_CPU_ADD && !adcPowerDown
            |=> sumAcc == $past(sumAcc) + {$past(sumHold), $past(sfrWdata)};
    endproperty
    a_cpu_add: assert property (p_cpu_add) else $error("cpu add result wrong");

    property p_shift_time;
        wrSsctrl && sfrWdata[SS_MODE_HI:SS_MODE_LO] == SUM_SHIFT && !adcPowerDown
            |=> state == ASC_SHIFTING [*4] ##1 (state == ASC_IDLE && sumIrq);
    endproperty
    a_shift_time: assert property (p_shift_time) else $error("shift did not complete in four clocks");

    property p_irq_read_clear;
        rdSum0 && !sumDone |=> !sumIrq;
    endproperty
    a_irq_read_clear: assert property (p_irq_read_clear) else $error("sum byte 0 read did not clear interrupt");

    property p_offset_dac_code_off;
        sfrWe && sfrAddr == ADDR_OFFSET_DAC_CODE && sfrWdata[6:0] == OFFSET_DAC_CODE_MAG_ZERO |=> !odacEnable;
    endproperty
    a_offset_dac_code_off: assert property (p_offset_dac_code_off) else $error("offset converter left on for zero code");
endmodule // asc_adc_sum_cal
`default_nettype wire

// ### dv/asc_conv_model.sv
// asc_conv_model: converter result source standing in for the modulator
`timescale 1ns/10ps
`default_nettype none
module asc_conv_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // request from the bench
    input wire logic send,
    input wire logic [23:0] value,
    // converter result lines
    output logic adcResultValid,
    output logic [23:0] adcResult
);
    logic next_adcResultValid;
    logic [23:0] next_adcResult;
    // -------------------------------
    // one-cycle result, inverted data between results
    // -------------------------------
    always_comb begin
        next_adcResultValid = send;
        next_adcResult = send ? value : ~adcResult;
    end
    always_ff @(posedge ref_clk) begin
        adcResultValid <= rst ? 1'b0 : next_adcResultValid;
        adcResult <= rst ? 24'h000000 : next_adcResult;
    end
endmodule // asc_conv_model
`default_nettype wire

// ### dv/test_adc_summation_calibration.sv
// test_adc_summation_calibration: register-level tests of the converter control block
`timescale 1ns/10ps
`default_nettype none
module test_adc_summation_calibration;
    import asc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWe = 1'b0;
    logic sfrRe = 1'b0;
    logic [7:0] sfrWdata = 8'h00;
    logic adcPowerDown = 1'b0;
    logic [7:0] converterClockDivider = 8'h01;
    logic send = 1'b0;
    logic [23:0] sendValue = 24'h000000;
    logic [7:0] sfrRdata;
    logic adcResultValid, calStart, resultPolarity, dataRateTick, odacEnable, odacNegative, sumIrq;
    logic [23:0] adcResult;
    logic [2:0] calMode;
    logic [1:0] settlingMode;
    logic [10:0] decimRatio;
    logic [6:0] odacMagnitude;
    int err_total = 0;
    int n_tests = 0;
    int k;
    always #2 ref_clk = ~ref_clk;
    asc_adc_sum_cal i_asc_adc_sum_cal (.ref_clk(ref_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
        .sfrRe(sfrRe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .adcPowerDown(adcPowerDown),
        .adcResultValid(adcResultValid), .adcResult(adcResult), .converterClockDivider(converterClockDivider),
        .calStart(calStart), .calMode(calMode), .resultPolarity(resultPolarity), .settlingMode(settlingMode),
        .decimRatio(decimRatio), .dataRateTick(dataRateTick), .odacEnable(odacEnable),
        .odacNegative(odacNegative), .odacMagnitude(odacMagnitude), .sumIrq(sumIrq));
    asc_conv_model i_asc_conv_model (.ref_clk(ref_clk), .rst(rst), .send(send), .value(sendValue),
        .adcResultValid(adcResultValid), .adcResult(adcResult));
    // -------------------------------
    // bus tasks and comparison
    // -------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWe <= 1'b1;
        @(posedge ref_clk);
        sfrWe <= 1'b0;
        #1;
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfrAddr <= a;
        sfrRe <= 1'b1;
        @(posedge ref_clk);
        sfrRe <= 1'b0;
        #1;
        chk(what, {24'h0, exp}, {24'h0, sfrRdata});
    endtask
    task automatic addv(input logic [31:0] v);
        wr(ADDR_SUM1, v[15:8]);
        wr(ADDR_SUM2, v[23:16]);
        wr(ADDR_SUM3, v[31:24]);
        wr(ADDR_SUM0, v[7:0]);
    endtask
    task automatic rsum(input logic [31:0] exp);
        for (int i = 0; i < 4; i++) begin
            rc("sumByte", ADDR_SUM0 + 8'(i), exp[8*i+:8]);
        end
    endtask
    task automatic sendv(input logic [23:0] v);
        @(posedge ref_clk);
        send <= 1'b1;
        sendValue <= v;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // -------------------------------
    // watchdog
    // -------------------------------
    initial begin
        #200000;
        err_total++;
        summarize();
    end
    // -------------------------------
    // tests
    // -------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rc("decimLow", ADDR_DECIM_LO, 8'h1B);
        rc("decimHigh", ADDR_DECIM_HI, 8'h06);
        chk("decimRatio", 32'h61B, 32'(decimRatio));
        rc("ssCtrl", ADDR_SSCTRL, 8'h00);
        for (int i = 0; i < 5; i++) rc("zeroReg", ADDR_SUM0 + 8'(i), 8'h00);
        wr(8'hD0, 8'h5A);
        rc("unmapped", 8'hD0, 8'h00);
        $display("test reset done");
        wr(ADDR_OFFSET_DAC_CODE, 8'h00);
        for (int c = 1; c < 8; c++) begin
            wr(ADDR_CTRL1, 8'(c));
            chk("calStart", 32'(c < 6), 32'(calStart));
            chk("calMode", (c < 6) ? 32'(c) : 32'h5, 32'(calMode));
            rc("ctrlRead", ADDR_CTRL1, 8'h00);
        end
        $display("test calibration done");
        wr(ADDR_OFFSET_DAC_CODE, 8'h80);
        chk("odacOff", 32'h0, 32'(odacEnable));
        wr(ADDR_OFFSET_DAC_CODE, 8'h85);
        chk("odacCode", 32'h185, 32'({odacEnable, odacNegative, odacMagnitude}));
        rc("odacRead", ADDR_OFFSET_DAC_CODE, 8'h85);
        wr(ADDR_OFFSET_DAC_CODE, 8'h00);
        chk("odacZero", 32'h0, 32'(odacEnable));
        $display("test offset done");
        wr(ADDR_SSCTRL, 8'h00);
        addv(32'h01020304);
        addv(32'h10FFFFFF);
        rsum(32'h12020303);
        wr(ADDR_SSCTRL, 8'h00);
        rsum(32'h00000000);
        @(posedge ref_clk);
        adcPowerDown <= 1'b1;
        addv(32'h00000005);
        @(posedge ref_clk);
        adcPowerDown <= 1'b0;
        rsum(32'h00000000);
        $display("test cpu sum done");
        wr(ADDR_CTRL1, 8'h70);
        chk("ctrlOut", 32'h7, 32'({resultPolarity, settlingMode}));
        rc("ctrlBits", ADDR_CTRL1, 8'h70);
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_SSCTRL, 8'h00);
            addv(32'h80000000);
            wr(ADDR_SSCTRL, 8'h80 | 8'(s));
            repeat (5) @(posedge ref_clk);
            #1;
            chk("shiftIrq", 32'h1, 32'(sumIrq));
            rsum(32'h80000000 >> (s + 1));
            chk("irqCleared", 32'h0, 32'(sumIrq));
        end
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_SSCTRL, 8'h00);
        addv(32'h80000000);
        wr(ADDR_SSCTRL, 8'h80);
        repeat (5) @(posedge ref_clk);
        rsum(32'hC0000000);
        $display("test shift done");
        wr(ADDR_CTRL1, 8'h40);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_SSCTRL, 8'h00);
            wr(ADDR_SSCTRL, 8'h40 | 8'(c << 3));
            for (int n = 1; n < (2 << c); n++) sendv(24'h000001);
            chk("earlyIrq", 32'h0, 32'(sumIrq));
            sendv(24'h000001);
            chk("countIrq", 32'h1, 32'(sumIrq));
            rsum(32'(2 << c));
        end
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_SSCTRL, 8'h00);
        wr(ADDR_SSCTRL, 8'hC0);
        sendv(24'hFFFFFE);
        sendv(24'hFFFFFE);
        repeat (8) @(posedge ref_clk);
        #1;
        chk("accShiftIrq", 32'h1, 32'(sumIrq));
        rsum(32'hFFFFFFFC >> 1 | 32'h80000000);
        $display("test converter sum done");
        wr(ADDR_DECIM_LO, 8'h02);
        wr(ADDR_DECIM_HI, 8'h00);
        chk("decimRatio", 32'h2, 32'(decimRatio));
        k = 0;
        while (dataRateTick !== 1'b1 && k < 600) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk("rateStart", 32'h1, 32'(dataRateTick));
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (dataRateTick !== 1'b1 && k < 600);
        chk("ratePeriod", 32'd256, 32'(k));
        $display("test rate done");
        summarize();
    end
endmodule // test_adc_summation_calibration
`default_nettype wire
